//--- logic/plp_nvarray.sv
// byte array with bit-clearing programming, bulk erase and two read ports
`include "plp_regs.svh"
module plp_nvarray #(
  parameter int AW = 6,
  parameter int DEPTH = 64
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic erase_i,
  input wire logic program_strobe_i,
  input wire logic [AW-1:0] program_strobe_addr_i,
  input wire logic [7:0] program_strobe_data_i,
  input wire logic [AW-1:0] rd_a_addr_i,
  output logic [7:0] rd_a_data_o,
  input wire logic [AW-1:0] rd_b_addr_i,
  output logic [7:0] rd_b_data_o
);
  logic [7:0] cell_q [DEPTH];

  // programming only clears bits; erase returns every cell to ones
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        cell_q[i] <= `PLP_ERASED_BYTE;
      end
    end else if (erase_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        cell_q[i] <= `PLP_ERASED_BYTE;
      end
    end else if (program_strobe_i) begin
      cell_q[program_strobe_addr_i] <= cell_q[program_strobe_addr_i] & program_strobe_data_i;
    end
  end

  assign rd_a_data_o = cell_q[rd_a_addr_i];
  assign rd_b_data_o = cell_q[rd_b_addr_i];
endmodule

//--- logic/plp_pkg.sv
// types shared by the program lock block
package plp_pkg;
  typedef enum logic [1:0] {
    PLP_LVL_OPEN,
    PLP_LVL_TABLE,
    PLP_LVL_NOVERIFY,
    PLP_LVL_NOEXT
  } plp_level_t;
  typedef enum logic [2:0] {
    PLP_MODE_IDLE,
    PLP_MODE_PROGRAM_STROBE_CODE,
    PLP_MODE_VERIFY,
    PLP_MODE_PROGRAM_STROBE_ENC,
    PLP_MODE_LOCK1,
    PLP_MODE_LOCK2,
    PLP_MODE_LOCK3
  } plp_mode_t;
endpackage

//--- logic/plp_regs.svh
// register offsets, field positions, reset values and timing counts for the program lock block
`ifndef PLP_REGS_SVH
`define PLP_REGS_SVH
`define PLP_ADDR_W 4
`define PLP_OFS_STATUS 4'h0
`define PLP_OFS_CONTROL 4'h4
`define PLP_ST_LOCK_LSB 0
`define PLP_ST_LOCK_MSB 2
`define PLP_ST_LEVEL_LSB 3
`define PLP_ST_LEVEL_MSB 4
`define PLP_ST_XSEL_BIT 5
`define PLP_CTL_ERASE_BIT 0
`define PLP_LOCK_RESET 3'h0
`define PLP_ERASED_BYTE 8'hFF
`define PLP_BLOCKED_BYTE 8'hFF
`define PLP_READ_ZERO 32'h0000_0000
`define PLP_CODE_AW 14
`define PLP_CODE_DEPTH 16384
`define PLP_ENC_AW 6
`define PLP_ENC_DEPTH 64
`define PLP_CLK_MHZ 50
`define PLP_STROBE_MIN_US 90
`define PLP_STROBE_MAX_US 110
`define PLP_STROBE_MIN_CYC (`PLP_STROBE_MIN_US * `PLP_CLK_MHZ)
`define PLP_STROBE_MAX_CYC (`PLP_STROBE_MAX_US * `PLP_CLK_MHZ)
`define PLP_STROBE_CNT_W 13
`endif

//--- logic/plp_top.sv
// program lock protection with programming, verify and register port
`include "plp_regs.svh"
// What this block does
// (R1) unlocked: no protection, yet verify output is still xnor-encrypted
// (R2) lock one: table reads run from external memory get no internal bytes
// (R3) level two up: external-access select latched in reset, pin then ignored
// (R4) level two up: programming pulses leave program memory unchanged
// (R5) lock one and two: level-two limits plus verify read-out disabled
// (R6) all locks: level-three limits plus external execution blocked
// (R7) programmer sets lock bits only in listed cumulative order
// (R8) erased cells read as ones, erased byte is all ones
// (R9) programmer holds address stable 48 periods before strobe falls
// (R10) programmer keeps address 48 periods after strobe rises
// (R11) programmer presents data 48 periods before strobe falls
// (R12) strobe low 90 to 110 us, at least 10 us high between; the block checks only the low width, not the high time
// (R13) verify data valid within 48 periods of address
// (R14) verify data valid within 48 periods of enable low
// (R15) data outputs released within 48 periods of enable high
// (R16) erase clears code, encryption array and lock bits to unprotected
// (R17) verify returns code xnor encryption byte chosen by six address bits
// (R18) programmer gives 5 pulses per code byte, 25 per other target
// (R19) protection level decoded from lock bits and applied continuously
// (R20) programmer counts oscillator periods for setup and hold
module plp_top #(
  parameter int STROBE_MIN_CYC = `PLP_STROBE_MIN_CYC,
  parameter int STROBE_MAX_CYC = `PLP_STROBE_MAX_CYC
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [`PLP_ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  input wire plp_pkg::plp_mode_t program_strobe_mode_i,
  input wire logic program_strobe_supply_high_i,
  input wire logic program_strobe_n_i,
  input wire logic verify_enable_n_i,
  input wire logic [`PLP_CODE_AW-1:0] program_strobe_addr_i,
  input wire logic [7:0] program_strobe_data_i,
  output logic [7:0] program_strobe_data_o,
  output logic program_strobe_data_oe_o,
  input wire logic chip_reset_i,
  input wire logic external_access_select_i,
  output logic external_access_eff_o,
  input wire logic cpu_rd_i,
  input wire logic [`PLP_CODE_AW-1:0] cpu_rd_addr_i,
  input wire logic cpu_rd_table_i,
  input wire logic cpu_run_external_i,
  output logic [7:0] cpu_rd_data_o,
  output logic cpu_rd_blocked_o,
  output logic ext_exec_en_o
);
  logic [2:0] lock_q;
  plp_pkg::plp_level_t level;
  logic erase_q;
  logic strobe_n_q;
  logic [`PLP_STROBE_CNT_W-1:0] low_cnt_q;
  logic pulse_ok;
  logic code_program_strobe_q;
  logic enc_program_strobe_q;
  logic [`PLP_CODE_AW-1:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic xsel_latch_q;
  logic [7:0] code_ver;
  logic [7:0] code_cpu;
  logic [7:0] enc_ver;
  logic verify_on;
  logic table_block;

  // level decode; undefined patterns treated as fully locked
  always_comb begin
    unique case (lock_q)
      3'h0: level = plp_pkg::PLP_LVL_OPEN; // R19
      3'h1: level = plp_pkg::PLP_LVL_TABLE;
      3'h3: level = plp_pkg::PLP_LVL_NOVERIFY;
      default: level = plp_pkg::PLP_LVL_NOEXT;
    endcase
  end

  // register writes: erase request
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      erase_q <= 1'b0;
    end else begin
      erase_q <= reg_we_i && (reg_addr_i == `PLP_OFS_CONTROL)
                 && reg_wdata_i[`PLP_CTL_ERASE_BIT];
    end
  end

  // register reads, data one cycle later
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= `PLP_READ_ZERO;
    end else if (reg_re_i) begin
      reg_rdata_o <= `PLP_READ_ZERO;
      if (reg_addr_i == `PLP_OFS_STATUS) begin
        reg_rdata_o[`PLP_ST_LOCK_MSB:`PLP_ST_LOCK_LSB] <= lock_q;
        reg_rdata_o[`PLP_ST_LEVEL_MSB:`PLP_ST_LEVEL_LSB] <= level;
        reg_rdata_o[`PLP_ST_XSEL_BIT] <= xsel_latch_q;
      end
    end
  end

  // strobe low-width measurement
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strobe_n_q <= 1'b1;
      low_cnt_q <= '0;
    end else begin
      strobe_n_q <= program_strobe_n_i;
      if (program_strobe_n_i) begin
        low_cnt_q <= '0;
      end else if (low_cnt_q != '1) begin
        low_cnt_q <= low_cnt_q + `PLP_STROBE_CNT_W'(1);
      end
    end
  end

  // pulse accepted on rising strobe when width fits and supply is high
  assign pulse_ok = !strobe_n_q && program_strobe_n_i && program_strobe_supply_high_i
                    && (low_cnt_q >= `PLP_STROBE_CNT_W'(STROBE_MIN_CYC))
                    && (low_cnt_q <= `PLP_STROBE_CNT_W'(STROBE_MAX_CYC));

  // programming of code and encryption bytes
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      code_program_strobe_q <= 1'b0;
      enc_program_strobe_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= `PLP_ERASED_BYTE;
    end else begin
      code_program_strobe_q <= pulse_ok && (program_strobe_mode_i == plp_pkg::PLP_MODE_PROGRAM_STROBE_CODE)
                     && (level == plp_pkg::PLP_LVL_OPEN); // R4
      enc_program_strobe_q <= pulse_ok && (program_strobe_mode_i == plp_pkg::PLP_MODE_PROGRAM_STROBE_ENC)
                    && (level == plp_pkg::PLP_LVL_OPEN); // R4
      wr_addr_q <= program_strobe_addr_i;
      wr_data_q <= program_strobe_data_i;
    end
  end

  // lock bits: set by pulses, cleared by erase or reset
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lock_q <= `PLP_LOCK_RESET;
    end else if (erase_q) begin
      lock_q <= `PLP_LOCK_RESET; // R16
    end else if (pulse_ok) begin
      if (program_strobe_mode_i == plp_pkg::PLP_MODE_LOCK1) begin
        lock_q[0] <= 1'b1;
      end
      if (program_strobe_mode_i == plp_pkg::PLP_MODE_LOCK2) begin
        lock_q[1] <= 1'b1;
      end
      if (program_strobe_mode_i == plp_pkg::PLP_MODE_LOCK3) begin
        lock_q[2] <= 1'b1;
      end
    end
  end

  plp_nvarray #(
    .AW(`PLP_CODE_AW),
    .DEPTH(`PLP_CODE_DEPTH)
  ) u_code (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .erase_i(erase_q), // R8 R16
    .program_strobe_i(code_program_strobe_q),
    .program_strobe_addr_i(wr_addr_q),
    .program_strobe_data_i(wr_data_q),
    .rd_a_addr_i(program_strobe_addr_i),
    .rd_a_data_o(code_ver),
    .rd_b_addr_i(cpu_rd_addr_i),
    .rd_b_data_o(code_cpu)
  );

  plp_nvarray #(
    .AW(`PLP_ENC_AW),
    .DEPTH(`PLP_ENC_DEPTH)
  ) u_enc (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .erase_i(erase_q), // R16
    .program_strobe_i(enc_program_strobe_q),
    .program_strobe_addr_i(wr_addr_q[`PLP_ENC_AW-1:0]),
    .program_strobe_data_i(wr_data_q),
    .rd_a_addr_i(program_strobe_addr_i[`PLP_ENC_AW-1:0]), // R17
    .rd_a_data_o(enc_ver),
    .rd_b_addr_i(`PLP_ENC_AW'(0)),
    .rd_b_data_o()
  );

  // verify read-out
  assign verify_on = (program_strobe_mode_i == plp_pkg::PLP_MODE_VERIFY) && !verify_enable_n_i
                     && (level < plp_pkg::PLP_LVL_NOVERIFY); // R5

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      program_strobe_data_o <= `PLP_ERASED_BYTE;
      program_strobe_data_oe_o <= 1'b0;
    end else begin
      program_strobe_data_oe_o <= verify_on; // R14 R15
      if (verify_on) begin
        program_strobe_data_o <= ~(code_ver ^ enc_ver); // R1 R13 R17
      end
    end
  end

  // external-access select latch and effective value
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      xsel_latch_q <= 1'b0;
      external_access_eff_o <= 1'b0;
    end else begin
      if (chip_reset_i) begin
        xsel_latch_q <= external_access_select_i; // R3
      end
      external_access_eff_o <= (level == plp_pkg::PLP_LVL_OPEN)
                               ? external_access_select_i : xsel_latch_q; // R3
    end
  end

  // cpu code reads and external execution
  assign table_block = cpu_rd_table_i && cpu_run_external_i
                       && (level != plp_pkg::PLP_LVL_OPEN); // R2

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cpu_rd_data_o <= `PLP_BLOCKED_BYTE;
      cpu_rd_blocked_o <= 1'b0;
      ext_exec_en_o <= 1'b1;
    end else begin
      cpu_rd_blocked_o <= cpu_rd_i && table_block;
      if (cpu_rd_i) begin
        cpu_rd_data_o <= table_block ? `PLP_BLOCKED_BYTE : code_cpu; // R2
      end
      ext_exec_en_o <= (level != plp_pkg::PLP_LVL_NOEXT); // R6
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  property p_open_table;
    (level == plp_pkg::PLP_LVL_OPEN) && cpu_rd_i && cpu_rd_table_i |=>
      !cpu_rd_blocked_o && (cpu_rd_data_o == $past(code_cpu));
  endproperty
  a_open_table: assert property (p_open_table) else $error("open level blocked read"); // R1

  property p_table_block;
    (level != plp_pkg::PLP_LVL_OPEN) && cpu_rd_i && cpu_rd_table_i && cpu_run_external_i
      |=> cpu_rd_blocked_o && (cpu_rd_data_o == `PLP_BLOCKED_BYTE);
  endproperty
  a_table_block: assert property (p_table_block) else $error("table read leaked"); // R2

  // level must stay locked over both cycles, an erase reopens the pin path
  property p_xsel_hold;
    (level != plp_pkg::PLP_LVL_OPEN) && !chip_reset_i
      ##1 (level != plp_pkg::PLP_LVL_OPEN) && !chip_reset_i
      |-> $stable(xsel_latch_q) ##1 (external_access_eff_o == $past(xsel_latch_q));
  endproperty
  a_xsel_hold: assert property (p_xsel_hold) else $error("select latch not held"); // R3

  property p_no_program_strobe;
    pulse_ok && (level != plp_pkg::PLP_LVL_OPEN) |=> !code_program_strobe_q && !enc_program_strobe_q;
  endproperty
  a_no_program_strobe: assert property (p_no_program_strobe) else $error("locked part programmed"); // R4

  property p_no_verify;
    (level >= plp_pkg::PLP_LVL_NOVERIFY) |=> !program_strobe_data_oe_o;
  endproperty
  a_no_verify: assert property (p_no_verify) else $error("verify not disabled"); // R5

  property p_no_ext;
    (level == plp_pkg::PLP_LVL_NOEXT) |=> !ext_exec_en_o;
  endproperty
  a_no_ext: assert property (p_no_ext) else $error("external execution allowed"); // R6

  property p_erase;
    erase_q |=> (lock_q == `PLP_LOCK_RESET) && (code_ver == `PLP_ERASED_BYTE)
      && (enc_ver == `PLP_ERASED_BYTE);
  endproperty
  a_erase: assert property (p_erase) else $error("erase incomplete"); // R8 R16

  property p_verify_data;
    (program_strobe_mode_i == plp_pkg::PLP_MODE_VERIFY) && !verify_enable_n_i
      && (level < plp_pkg::PLP_LVL_NOVERIFY)
      |=> program_strobe_data_oe_o && (program_strobe_data_o == ~($past(code_ver) ^ $past(enc_ver)));
  endproperty
  a_verify_data: assert property (p_verify_data) else $error("verify data wrong"); // R13 R14 R17

  property p_float;
    verify_enable_n_i |=> !program_strobe_data_oe_o;
  endproperty
  a_float: assert property (p_float) else $error("data not released"); // R15

  property p_decode;
    (lock_q == 3'h3) |-> (level == plp_pkg::PLP_LVL_NOVERIFY);
  endproperty
  a_decode: assert property (p_decode) else $error("level decode wrong"); // R19
endmodule

//--- sim/plp_programmer.sv
// programmer model on the programming and verify pins
module plp_programmer #(
  parameter int SETUP_CYC = 48,
  parameter int WIDTH_CYC = 6,
  parameter int GAP_CYC = 500
) (
  input wire logic clk_i,
  input wire logic [7:0] data_i,
  input wire logic oe_i,
  output plp_pkg::plp_mode_t mode_o,
  output logic sup_o,
  output logic stb_n_o,
  output logic ven_n_o,
  output logic [13:0] addr_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mode_o = plp_pkg::PLP_MODE_IDLE;
    sup_o = 1'b0;
    stb_n_o = 1'b1;
    ven_n_o = 1'b1;
    addr_o = 14'h0000;
    data_o = 8'h00;
  end
  // pulse train with setup and hold counted in clock periods
  task automatic burn(input plp_pkg::plp_mode_t m, input logic [13:0] a, input logic [7:0] d,
      input int n);
    mode_o <= m;
    addr_o <= a;
    data_o <= d;
    sup_o <= 1'b1;
    repeat (SETUP_CYC) @(posedge clk_i);
    repeat (n) begin
      stb_n_o <= 1'b0;
      repeat (WIDTH_CYC) @(posedge clk_i);
      stb_n_o <= 1'b1;
      repeat (GAP_CYC) @(posedge clk_i);
    end
    repeat (SETUP_CYC) @(posedge clk_i);
    sup_o <= 1'b0;
    mode_o <= plp_pkg::PLP_MODE_IDLE;
    addr_o <= ~a;
    data_o <= ~d;
    @(posedge clk_i);
  endtask
  // verify read, waits at most 49 periods each way
  task automatic look(input logic [13:0] a, output logic [7:0] q, output logic drv,
      output logic rel);
    int n;
    mode_o <= plp_pkg::PLP_MODE_VERIFY;
    addr_o <= a;
    ven_n_o <= 1'b0;
    n = 0;
    @(posedge clk_i);
    while (oe_i !== 1'b1 && n < 48) begin
      @(posedge clk_i);
      n++;
    end
    drv = oe_i;
    q = data_i;
    ven_n_o <= 1'b1;
    n = 0;
    @(posedge clk_i);
    while (oe_i !== 1'b0 && n < 48) begin
      @(posedge clk_i);
      n++;
    end
    rel = ~oe_i;
    mode_o <= plp_pkg::PLP_MODE_IDLE;
    addr_o <= ~a;
    @(posedge clk_i);
  endtask
endmodule

//--- sim/plp_top_test.sv
// self-checking bench for the program lock block
module plp_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst_n = 1'b0;
  logic [3:0] ra = 4'h0;
  logic [31:0] wd = 32'h0000_0000;
  logic we = 1'b0;
  logic re = 1'b0;
  logic crst = 1'b1;
  logic eap = 1'b0;
  logic crd = 1'b0;
  logic ctb = 1'b0;
  logic cex = 1'b0;
  logic [13:0] ca = 14'h0000;
  plp_pkg::plp_mode_t mode;
  logic sup, stb_n, ven_n, oe, eeff, cblk, xen, f, b;
  logic [13:0] pa;
  logic [7:0] pd, pq, cq, q;
  logic [31:0] rd, w;
  int err_count = 0;
  int samples_checked = 0;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  plp_top #(.STROBE_MIN_CYC(4), .STROBE_MAX_CYC(8)) dut (
    .clk_sys_i(clk), .reset_n_i(rst_n), .reg_addr_i(ra), .reg_wdata_i(wd),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rd), .program_strobe_mode_i(mode),
    .program_strobe_supply_high_i(sup), .program_strobe_n_i(stb_n), .verify_enable_n_i(ven_n),
    .program_strobe_addr_i(pa), .program_strobe_data_i(pd), .program_strobe_data_o(pq), .program_strobe_data_oe_o(oe),
    .chip_reset_i(crst), .external_access_select_i(eap), .external_access_eff_o(eeff),
    .cpu_rd_i(crd), .cpu_rd_addr_i(ca), .cpu_rd_table_i(ctb), .cpu_run_external_i(cex),
    .cpu_rd_data_o(cq), .cpu_rd_blocked_o(cblk), .ext_exec_en_o(xen));
  plp_programmer #(.GAP_CYC(10)) prg (
    .clk_i(clk), .data_i(pq), .oe_i(oe), .mode_o(mode), .sup_o(sup), .stb_n_o(stb_n),
    .ven_n_o(ven_n), .addr_o(pa), .data_o(pd));
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    ra <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    ra <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(posedge clk);
    d = rd;
  endtask
  task automatic cpu_read(input logic [13:0] a, input logic t, input logic x);
    ca <= a;
    ctb <= t;
    cex <= x;
    crd <= 1'b1;
    @(posedge clk);
    crd <= 1'b0;
    @(posedge clk);
    q = cq;
    f = cblk;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("[FAIL] run expected done seen hang");
    finish_test;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    reg_rd(4'h0, w);
    chk_word("status", 32'h0000_0000, w);
    reg_rd(4'h8, w);
    chk_word("unmapped", 32'h0000_0000, w);
    chk_byte("exec", 8'h01, {7'h00, xen});
    prg.look(14'h0123, q, f, b);
    chk_byte("erased", 8'hFF, q);
    chk_byte("drive", 8'h01, {7'h00, f});
    chk_byte("release", 8'h01, {7'h00, b});
    crst <= 1'b0;
    eap <= 1'b1;
    repeat (3) @(posedge clk);
    chk_byte("xsel_open", 8'h01, {7'h00, eeff});
    eap <= 1'b0;
    prg.burn(plp_pkg::PLP_MODE_PROGRAM_STROBE_CODE, 14'h0045, 8'h3C, 5);
    prg.burn(plp_pkg::PLP_MODE_PROGRAM_STROBE_ENC, 14'h0005, 8'hA5, 25);
    prg.look(14'h0045, q, f, b);
    chk_byte("enc_code", 8'h66, q);
    prg.look(14'h0005, q, f, b);
    chk_byte("enc_blank", 8'hA5, q);
    cpu_read(14'h0045, 1'b1, 1'b1);
    chk_byte("cpu_open", 8'h3C, q);
    chk_byte("blk_open", 8'h00, {7'h00, f});
    prg.burn(plp_pkg::PLP_MODE_LOCK1, 14'h0000, 8'h00, 25);
    reg_rd(4'h0, w);
    chk_word("status_l1", 32'h0000_0009, w);
    cpu_read(14'h0045, 1'b1, 1'b1);
    chk_byte("cpu_l1", 8'hFF, q);
    chk_byte("blk_l1", 8'h01, {7'h00, f});
    cpu_read(14'h0045, 1'b1, 1'b0);
    chk_byte("cpu_int", 8'h3C, q);
    chk_byte("blk_int", 8'h00, {7'h00, f});
    eap <= 1'b1;
    repeat (3) @(posedge clk);
    chk_byte("xsel_held", 8'h00, {7'h00, eeff});
    crst <= 1'b1;
    repeat (3) @(posedge clk);
    crst <= 1'b0;
    eap <= 1'b0;
    repeat (3) @(posedge clk);
    chk_byte("xsel_latch", 8'h01, {7'h00, eeff});
    prg.burn(plp_pkg::PLP_MODE_PROGRAM_STROBE_CODE, 14'h0046, 8'h00, 5);
    prg.look(14'h0046, q, f, b);
    chk_byte("no_program_strobe", 8'hFF, q);
    prg.burn(plp_pkg::PLP_MODE_LOCK2, 14'h0000, 8'h00, 25);
    reg_rd(4'h0, w);
    chk_word("status_l2", 32'h0000_0033, w);
    prg.look(14'h0045, q, f, b);
    chk_byte("no_verify", 8'h00, {7'h00, f});
    cpu_read(14'h0045, 1'b1, 1'b1);
    chk_byte("blk_l2", 8'h01, {7'h00, f});
    prg.burn(plp_pkg::PLP_MODE_LOCK3, 14'h0000, 8'h00, 25);
    reg_rd(4'h0, w);
    chk_word("status_l3", 32'h0000_003F, w);
    chk_byte("exec_l3", 8'h00, {7'h00, xen});
    reg_wr(4'h4, 32'h0000_0001);
    reg_rd(4'h0, w);
    chk_word("status_er", 32'h0000_0000, w & 32'h0000_001F);
    prg.look(14'h0045, q, f, b);
    chk_byte("erase_code", 8'hFF, q);
    chk_byte("exec_er", 8'h01, {7'h00, xen});
    finish_test;
  end
endmodule
